// ===== rtl/capture_filter_chain.v
/*
 capture filter chain: path select, first-order high-pass, wind filter,
 boost, volume with soft ramp, and a small register port.
 assumes converter samples arrive one per sample period, synchronous to clk.
*/
// Our own choices: the register offsets and strobed register access.
`timescale 1ns/1ps
`include "capture_consts.vh"
module capture_filter_chain (
  // clock and reset
  input wire clk,
  input wire rst_n,
  input wire clk_en,
  // register port
  input wire [3:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [7:0] reg_rdata_ff,
  // converter samples, both front-end paths
  input wire sample_valid,
  input wire signed [23:0] hiamp_sample,
  input wire signed [23:0] lownoise_sample,
  // capture output
  output reg signed [23:0] capture_out_ff,
  output reg capture_valid_ff,
  output reg path_lownoise_ff
);
  reg [7:0] ctrl_ff;
  reg [7:0] corner_ff;
  reg [7:0] capture_volume_ff;
  reg [7:0] ramp_rate_ff;
  reg [7:0] vol_applied_ff;
  reg [7:0] ramp_cnt_ff;
  reg [7:0] hold_cnt_ff;
  reg signed [23:0] front_ff;
  reg front_valid_ff;

  wire capture_highpass_enable = ctrl_ff[`CTRL_HPF_EN];
  wire wind_filter_enable = ctrl_ff[`CTRL_WNF_EN];
  wire capture_gain_boost = ctrl_ff[`CTRL_BOOST];
  wire capture_ramp_enable = ctrl_ff[`CTRL_RAMP_EN];
  wire [1:0] capture_highpass_corner_sel = corner_ff[1:0];
  wire [1:0] wind_filter_corner_sel = corner_ff[5:4];

  wire signed [23:0] hpf_out;
  wire hpf_valid;
  wire signed [23:0] wnf_out;
  wire wnf_valid;

  // saturate a wide value to 24 bits
  function [23:0] sat24;
    input signed [47:0] v;
    begin
      if (v > 48'sh0000007FFFFF)
        sat24 = 24'h7FFFFF;
      else if (v < -48'sh000000800000)
        sat24 = 24'h800000;
      else
        sat24 = v[23:0];
    end
  endfunction

  // magnitude of a sample, saturated so the most negative value fits
  function [23:0] mag24;
    input signed [23:0] v;
    begin
      if (v == 24'h800000)
        mag24 = 24'h7FFFFF;
      else if (v[23])
        mag24 = -v;
      else
        mag24 = v;
    end
  endfunction

  // clamp a volume code into the legal span; mute passes as is
  function [7:0] vol_clamp;
    input [7:0] v;
    begin
      if (v == `VOL_MUTE)
        vol_clamp = v;
      else if (!v[7] && v > `VOL_MAX)
        vol_clamp = `VOL_MAX;
      else if (v[7] && v < `VOL_MIN)
        vol_clamp = `VOL_MIN;
      else
        vol_clamp = v;
    end
  endfunction

  // register writes
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_ff <= `CTRL_RESET;
      corner_ff <= `CORNER_RESET;
      capture_volume_ff <= `VOL_RESET;
      ramp_rate_ff <= `RAMP_RESET;
    end else if (clk_en && reg_wr) begin
      case (reg_addr)
        `REG_CTRL: ctrl_ff <= {4'h0, reg_wdata[3:0]};
        `REG_CORNER: corner_ff <= {2'h0, reg_wdata[5:4], 2'h0, reg_wdata[1:0]};
        `REG_VOLUME: capture_volume_ff <= vol_clamp(reg_wdata);
        `REG_RAMP: begin
          if (reg_wdata < `RAMP_MIN)
            ramp_rate_ff <= `RAMP_MIN;
          else if (reg_wdata > `RAMP_MAX)
            ramp_rate_ff <= `RAMP_MAX;
          else
            ramp_rate_ff <= reg_wdata;
        end
        default: ctrl_ff <= ctrl_ff;
      endcase
    end
  end

  // register reads, data one cycle after the strobe; unmapped reads zero
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata_ff <= 8'h00;
    end else if (clk_en) begin
      if (reg_rd) begin
        case (reg_addr)
          `REG_CTRL: reg_rdata_ff <= ctrl_ff;
          `REG_CORNER: reg_rdata_ff <= corner_ff;
          `REG_VOLUME: reg_rdata_ff <= capture_volume_ff;
          `REG_RAMP: reg_rdata_ff <= ramp_rate_ff;
          `REG_STATUS: reg_rdata_ff <= vol_applied_ff;
          default: reg_rdata_ff <= 8'h00;
        endcase
      end else begin
        reg_rdata_ff <= 8'h00;
      end
    end
  end

  // path select with hysteresis and hold to avoid toggling per sample
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      path_lownoise_ff <= 1'b0;
      hold_cnt_ff <= 8'h00;
      front_ff <= 24'h0;
      front_valid_ff <= 1'b0;
    end else if (clk_en) begin
      front_valid_ff <= sample_valid;
      if (sample_valid) begin
        if (path_lownoise_ff && mag24(lownoise_sample) >= `PATH_HI_THRESH) begin
          path_lownoise_ff <= 1'b0;
          hold_cnt_ff <= `PATH_HOLD;
          front_ff <= hiamp_sample;
        end else if (!path_lownoise_ff && mag24(hiamp_sample) < `PATH_LO_THRESH) begin
          if (hold_cnt_ff == 8'h00) begin
            path_lownoise_ff <= 1'b1;
            front_ff <= lownoise_sample;
          end else begin
            hold_cnt_ff <= hold_cnt_ff - 8'h01;
            front_ff <= hiamp_sample;
          end
        end else begin
          if (!path_lownoise_ff)
            hold_cnt_ff <= `PATH_HOLD;
          front_ff <= path_lownoise_ff ? lownoise_sample : hiamp_sample;
        end
      end
    end
  end

  // high-pass first, wind filter second
  highpass_first u_hpf (
    .clk(clk),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .enable(capture_highpass_enable),
    .corner_sel(capture_highpass_corner_sel),
    .sample_valid(front_valid_ff),
    .sample_in(front_ff),
    .sample_out_ff(hpf_out),
    .out_valid_ff(hpf_valid)
  );

  wind_filter u_wnf (
    .clk(clk),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .enable(wind_filter_enable),
    .corner_sel(wind_filter_corner_sel),
    .sample_valid(hpf_valid),
    .sample_in(hpf_out),
    .sample_out_ff(wnf_out),
    .out_valid_ff(wnf_valid)
  );

  // soft ramp: one step per ramp_rate sample periods
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      vol_applied_ff <= `VOL_RESET;
      ramp_cnt_ff <= 8'h00;
    end else if (clk_en) begin
      if (!capture_ramp_enable || capture_volume_ff == `VOL_MUTE
          || vol_applied_ff == `VOL_MUTE) begin
        vol_applied_ff <= capture_volume_ff;
        ramp_cnt_ff <= 8'h00;
      end else if (sample_valid && vol_applied_ff != capture_volume_ff) begin
        if (ramp_cnt_ff + 8'h01 >= ramp_rate_ff) begin
          ramp_cnt_ff <= 8'h00;
          if ($signed(vol_applied_ff) < $signed(capture_volume_ff))
            vol_applied_ff <= vol_applied_ff + 8'h01;
          else
            vol_applied_ff <= vol_applied_ff - 8'h01;
        end else begin
          ramp_cnt_ff <= ramp_cnt_ff + 8'h01;
        end
      end else if (vol_applied_ff == capture_volume_ff) begin
        ramp_cnt_ff <= 8'h00;
      end
    end
  end

  // volume in 1 dB steps from 0 dB up: 6 dB per shift, residue from a small table (Q14)
  reg signed [47:0] boosted;
  reg signed [47:0] scaled;
  reg signed [8:0] db;
  reg [3:0] sh6;
  reg [2:0] rem;
  reg [15:0] frac;
  always @* begin
    // +20 dB is x10 exactly
    if (capture_gain_boost)
      boosted = {{24{wnf_out[23]}}, wnf_out} * 48'sd10;
    else
      boosted = {{24{wnf_out[23]}}, wnf_out};
    // code is signed dB with unity at 0 dB; the clamp keeps it at +12 or below
    db = {vol_applied_ff[7], vol_applied_ff};
    sh6 = 4'h0;
    rem = 3'h0;
    if (db >= 9'sd12) begin
      sh6 = 4'h2;
      rem = db[2:0] - 3'h4;
    end else if (db >= 9'sd6) begin
      sh6 = 4'h1;
      rem = db[2:0] - 3'h6;
    end else if (db >= 9'sd0) begin
      rem = db[2:0];
    end
    case (rem)
      3'h0: frac = 16'h4000;
      3'h1: frac = 16'h47FA;
      3'h2: frac = 16'h50C3;
      3'h3: frac = 16'h5A9E;
      3'h4: frac = 16'h65AC;
      default: frac = 16'h7214;
    endcase
    scaled = ((boosted * $signed({1'b0, frac})) >>> 14) <<< sh6;
    // attenuation: coarse 6 dB shift below unity
    if (db < 9'sd0)
      scaled = (boosted >>> ((-db + 9'sd5) / 9'sd6));
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      capture_out_ff <= 24'h0;
      capture_valid_ff <= 1'b0;
    end else if (clk_en) begin
      capture_valid_ff <= wnf_valid;
      if (wnf_valid) begin
        if (vol_applied_ff == `VOL_MUTE)
          capture_out_ff <= 24'h0;
        else
          capture_out_ff <= sat24(scaled);
      end
    end
  end
endmodule // capture_filter_chain

// ===== rtl/capture_consts.vh
/*
 constants for the capture filter chain: register offsets, field positions,
 reset values, widths and timing counts. assumes inclusion by bare name.
*/
`ifndef CAPTURE_CONSTS_VH
`define CAPTURE_CONSTS_VH
`define DATA_W 24
`define ACC_W 40
`define REG_CTRL 4'h0
`define REG_CORNER 4'h1
`define REG_VOLUME 4'h2
`define REG_RAMP 4'h3
`define REG_STATUS 4'h4
`define CTRL_HPF_EN 0
`define CTRL_WNF_EN 1
`define CTRL_BOOST 2
`define CTRL_RAMP_EN 3
`define CTRL_RESET 8'h01
`define CORNER_RESET 8'h00
`define VOL_RESET 8'h00
`define VOL_MAX 8'h0C
`define VOL_MIN 8'hA0
`define VOL_MUTE 8'h80
`define RAMP_RESET 8'h01
`define RAMP_MIN 8'h01
`define RAMP_MAX 8'h48
`define PATH_HI_THRESH 24'h200000
`define PATH_LO_THRESH 24'h100000
`define PATH_HOLD 8'h40
`endif

// ===== rtl/highpass_first.v
/*
 first-order dc-blocking high-pass stage, one sample per valid strobe.
 assumes samples arrive on sample_valid and that the corner select is static
 between samples.
*/
`timescale 1ns/1ps
`include "capture_consts.vh"
module highpass_first (
  // clock and reset
  input wire clk,
  input wire rst_n,
  input wire clk_en,
  // control
  input wire enable,
  input wire [1:0] corner_sel,
  // samples
  input wire sample_valid,
  input wire signed [23:0] sample_in,
  output reg signed [23:0] sample_out_ff,
  output reg out_valid_ff
);
  reg signed [39:0] state_ff;
  reg signed [39:0] nxt_state;
  reg signed [39:0] diff;
  reg [4:0] shift;

  // pole distance from one is 2^-shift; larger shift means lower corner
  always @* begin
    case (corner_sel)
      2'h0: shift = 5'h0A;
      2'h1: shift = 5'h09;
      2'h2: shift = 5'h08;
      default: shift = 5'h07;
    endcase
    diff = ({{16{sample_in[23]}}, sample_in} <<< 16) - state_ff;
    nxt_state = state_ff + (diff >>> shift);
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= 40'h0;
      sample_out_ff <= 24'h0;
      out_valid_ff <= 1'b0;
    end else if (clk_en) begin
      out_valid_ff <= sample_valid;
      if (sample_valid) begin
        if (enable) begin
          state_ff <= nxt_state;
          sample_out_ff <= diff[39:16];
        end else begin
          // bypass: offset passes straight through and may clip later
          state_ff <= 40'h0;
          sample_out_ff <= sample_in;
        end
      end
    end
  end
endmodule // highpass_first

// ===== rtl/wind_filter.v
/*
 fourth-order wind-noise high-pass: four cascaded first-order sections in
 one pass. assumes one sample per sample_valid strobe.
*/
`timescale 1ns/1ps
`include "capture_consts.vh"
module wind_filter (
  // clock and reset
  input wire clk,
  input wire rst_n,
  input wire clk_en,
  // control
  input wire enable,
  input wire [1:0] corner_sel,
  // samples
  input wire sample_valid,
  input wire signed [23:0] sample_in,
  output reg signed [23:0] sample_out_ff,
  output reg out_valid_ff
);
  reg signed [39:0] st_ff [0:3];
  reg signed [39:0] x [0:4];
  reg signed [39:0] d [0:3];
  reg [4:0] shift;
  integer i;
  integer j;

  always @* begin
    case (corner_sel)
      2'h0: shift = 5'h06;
      2'h1: shift = 5'h05;
      2'h2: shift = 5'h04;
      default: shift = 5'h03;
    endcase
    x[0] = {{16{sample_in[23]}}, sample_in} <<< 16;
    for (j = 0; j < 4; j = j + 1) begin
      d[j] = x[j] - st_ff[j];
      x[j + 1] = d[j];
    end
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (i = 0; i < 4; i = i + 1) begin
        st_ff[i] <= 40'h0;
      end
      sample_out_ff <= 24'h0;
      out_valid_ff <= 1'b0;
    end else if (clk_en) begin
      out_valid_ff <= sample_valid;
      if (sample_valid) begin
        if (enable) begin
          for (i = 0; i < 4; i = i + 1) begin
            st_ff[i] <= st_ff[i] + (d[i] >>> shift);
          end
          sample_out_ff <= x[4][39:16];
        end else begin
          for (i = 0; i < 4; i = i + 1) begin
            st_ff[i] <= 40'h0;
          end
          sample_out_ff <= sample_in;
        end
      end
    end
  end
endmodule // wind_filter

// ===== test/capture_filter_chain_assertions.sv
/*
 port checker for capture_filter_chain, bound to every instance.
 assumes one clock domain and rst_n asynchronous, active low.
*/
`timescale 1ns/1ps
`include "capture_consts.vh"
module capture_chk (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clk_en,
  // register port
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata_ff,
  // samples
  input wire logic sample_valid,
  input wire logic signed [23:0] capture_out_ff,
  input wire logic capture_valid_ff
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  wire rd_take = reg_rd && clk_en && !reg_wr;
  // write of the control word, a quiet cycle, then its read
  sequence ctrl_wr_rd;
    reg_wr && clk_en && reg_addr == `REG_CTRL ##1 !reg_wr ##1 rd_take && reg_addr == `REG_CTRL;
  endsequence
  sequence sample_run;
    sample_valid && clk_en ##1 clk_en [*3];
  endsequence
  chk_rd_idle: assert property (!(reg_rd && clk_en) |=> reg_rdata_ff == 8'h00)
    else $error("read data not zero outside a read");
  chk_rd_unmapped: assert property (rd_take && reg_addr > `REG_STATUS |=> reg_rdata_ff == 8'h00)
    else $error("unmapped read not zero");
  chk_ctrl_back: assert property (ctrl_wr_rd |=> (reg_rdata_ff & 8'h0F) == ($past(reg_wdata, 3) & 8'h0F))
    else $error("control readback wrong");
  chk_vol_range: assert property (rd_take && reg_addr == `REG_VOLUME |=>
    reg_rdata_ff == `VOL_MUTE
    || ($signed(reg_rdata_ff) <= 8'sh0C && $signed(reg_rdata_ff) >= 8'shA0))
    else $error("volume outside range");
  chk_ramp_range: assert property (rd_take && reg_addr == `REG_RAMP |=>
    reg_rdata_ff >= `RAMP_MIN && reg_rdata_ff <= `RAMP_MAX)
    else $error("ramp rate outside range");
  chk_valid_lat: assert property (sample_run |=> capture_valid_ff)
    else $error("output sample late");
  chk_valid_cause: assert property (capture_valid_ff |-> $past(sample_valid, 4))
    else $error("output sample without input");
  chk_out_hold: assert property (!capture_valid_ff |-> $stable(capture_out_ff))
    else $error("output changed without valid");
endmodule // capture_chk

bind capture_filter_chain capture_chk chk_u (.clk(clk), .rst_n(rst_n), .clk_en(clk_en),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata_ff(reg_rdata_ff), .sample_valid(sample_valid),
  .capture_out_ff(capture_out_ff), .capture_valid_ff(capture_valid_ff));

// ===== test/capture_filter_chain_tb_top.sv
/*
 self-checking bench for capture_filter_chain.
 assumes the design is fed equal samples on both front-end inputs.
*/
`timescale 1ns/1ps
`include "capture_consts.vh"
module capture_filter_chain_tb_top;
  logic clk, rst_n, reg_wr, reg_rd, sample_valid, capture_valid_ff, path_lownoise_ff;
  logic [3:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata_ff, rd_v;
  logic signed [23:0] hi_s, lo_s, capture_out_ff, out_v;
  logic signed [23:0] res [2];
  int fails, cmp_count;
  capture_filter_chain dut_u (.clk(clk), .rst_n(rst_n), .clk_en(1'b1), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_ff(reg_rdata_ff),
    .sample_valid(sample_valid), .hiamp_sample(hi_s), .lownoise_sample(lo_s),
    .capture_out_ff(capture_out_ff), .capture_valid_ff(capture_valid_ff),
    .path_lownoise_ff(path_lownoise_ff));
  initial begin
    clk = 0;
    forever #50 clk = ~clk;
  end
  task automatic check_byte(string what, logic [7:0] exp, logic [7:0] got);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("BAD %s exp %h got %h", what, exp, got);
    end
  endtask
  task automatic check_word(string what, logic [23:0] exp, logic [23:0] got);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("BAD %s exp %h got %h", what, exp, got);
    end
  endtask
  task automatic check_flag(string what, logic exp, logic got);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("BAD %s exp %b got %b", what, exp, got);
    end
  endtask
  task automatic do_reset;
    rst_n <= 0;
    repeat (10) @(posedge clk);
    rst_n <= 1;
    @(posedge clk);
  endtask
  task automatic wr(logic [3:0] a, logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1;
    @(posedge clk);
    reg_wr <= 0;
  endtask
  // read data stand only in the cycle after the strobe edge
  task automatic rd_chk(string what, logic [3:0] a, logic [7:0] exp);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1;
    @(posedge clk);
    reg_rd <= 0;
    #1 rd_v = reg_rdata_ff;
    check_byte(what, exp, rd_v);
  endtask
  task automatic send(logic signed [23:0] x);
    int n;
    @(posedge clk);
    hi_s <= x;
    lo_s <= x;
    sample_valid <= 1;
    @(posedge clk);
    sample_valid <= 0;
    n = 0;
    do begin
      @(posedge clk);
      #1 n++;
    end while (capture_valid_ff !== 1'b1 && n < 8);
    check_flag("valid", 1'b1, capture_valid_ff);
    out_v = capture_out_ff;
  endtask
  task automatic t_regs;
    logic [7:0] vw [5] = '{8'h7F, 8'h0C, 8'h90, 8'hA0, 8'h80};
    logic [7:0] ve [5] = '{8'h0C, 8'h0C, 8'hA0, 8'hA0, 8'h80};
    logic [7:0] rw [4] = '{8'h00, 8'hFF, 8'h48, 8'h01};
    logic [7:0] re [4] = '{8'h01, 8'h48, 8'h48, 8'h01};
    rd_chk("ctrl", `REG_CTRL, `CTRL_RESET);
    rd_chk("corner", `REG_CORNER, `CORNER_RESET);
    rd_chk("volume", `REG_VOLUME, `VOL_RESET);
    rd_chk("ramp", `REG_RAMP, `RAMP_RESET);
    rd_chk("status", `REG_STATUS, 8'h00);
    wr(4'hF, 8'hFF);
    rd_chk("unmapped", 4'hF, 8'h00);
    wr(`REG_CTRL, 8'h0F);
    rd_chk("ctrl", `REG_CTRL, 8'h0F);
    for (int i = 0; i < 5; i++) begin
      wr(`REG_VOLUME, vw[i]);
      rd_chk("volume", `REG_VOLUME, ve[i]);
    end
    for (int i = 0; i < 4; i++) begin
      wr(`REG_RAMP, rw[i]);
      rd_chk("ramp", `REG_RAMP, re[i]);
    end
    wr(`REG_CTRL, 8'h00);
    send(24'h012345);
    check_word("mute", 24'h000000, out_v);
    wr(`REG_VOLUME, 8'h00);
    $display("test regs done");
  endtask
  task automatic t_bypass;
    send(24'h012345);
    check_word("bypass", 24'h012345, out_v);
    send(24'h800001);
    check_word("offset", 24'h800001, out_v);
    wr(`REG_CTRL, 8'h04);
    send(24'h001000);
    check_flag("boost", 1'b1, out_v >= 24'sh009000 && out_v <= 24'sh00B000);
    wr(`REG_CTRL, 8'h00);
    wr(`REG_VOLUME, 8'h0C);
    send(24'h001000);
    check_word("gain max", 24'h004000, out_v);
    wr(`REG_VOLUME, 8'h00);
    $display("test bypass done");
  endtask
  // a dc step decays faster at the higher corner code
  task automatic t_corner(bit wind);
    for (int k = 0; k < 2; k++) begin
      do_reset;
      wr(`REG_CTRL, wind ? 8'h02 : 8'h01);
      wr(`REG_CORNER, wind ? (k ? 8'h03 : 8'h30) : (k ? 8'h00 : 8'h03));
      repeat (64) send(24'h100000);
      res[k] = out_v < 0 ? -out_v : out_v;
    end
    if (wind) begin
      check_flag("wind fast", 1'b1, res[0] < 24'sh010000);
      check_flag("wind slow", 1'b1, res[1] > 24'sh010000);
    end else begin
      check_flag("hpf fast", 1'b1, res[0] < 24'sh0C0000);
      check_flag("hpf slow", 1'b1, res[1] > 24'sh0C0000);
    end
    $display("test corner done");
  endtask
  task automatic t_ramp;
    logic signed [7:0] prev;
    prev = 8'sh00;
    wr(`REG_CTRL, 8'h08);
    wr(`REG_VOLUME, 8'hF4);
    repeat (14) begin
      send(24'h000000);
      rd_chk("ramp status", `REG_STATUS, (prev == -8'sd12) ? prev : prev - 8'sd1);
      check_flag("ramp step", 1'b1, prev - $signed(rd_v) inside {0, 1});
      prev = rd_v;
    end
    check_byte("ramp end", 8'hF4, rd_v);
    send(24'h010000);
    check_word("atten", 24'h004000, out_v);
    // slower rate: one step only after three sample periods
    wr(`REG_RAMP, 8'h03);
    wr(`REG_VOLUME, 8'hF6);
    repeat (2) send(24'h000000);
    rd_chk("ramp wait", `REG_STATUS, 8'hF4);
    send(24'h000000);
    rd_chk("ramp slow", `REG_STATUS, 8'hF5);
    wr(`REG_CTRL, 8'h00);
    wr(`REG_VOLUME, 8'h00);
    rd_chk("ramp off", `REG_STATUS, 8'h00);
    $display("test ramp done");
  endtask
  task automatic t_path;
    do_reset;
    wr(`REG_CTRL, 8'h00);
    repeat (70) send(24'h000100);
    check_flag("low noise", 1'b1, path_lownoise_ff);
    send(24'h300000);
    check_flag("high amp", 1'b0, path_lownoise_ff);
    repeat (64) send(24'h000100);
    check_flag("path hold", 1'b0, path_lownoise_ff);
    send(24'h000100);
    check_flag("path back", 1'b1, path_lownoise_ff);
    $display("test path done");
  endtask
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial begin
    rst_n = 0;
    reg_wr = 0;
    reg_rd = 0;
    reg_addr = 4'h0;
    reg_wdata = 8'h00;
    sample_valid = 0;
    hi_s = 24'h000000;
    lo_s = 24'h000000;
    do_reset;
    t_regs;
    t_bypass;
    t_corner(0);
    t_corner(1);
    t_ramp;
    t_path;
    report_and_stop;
  end
  // whole run is a few thousand cycles; this leaves wide margin
  initial begin
    #2000000;
    fails++;
    $display("watchdog expired");
    report_and_stop;
  end
endmodule // capture_filter_chain_tb_top
